// ===== fa_top.sv
// Fault aggregation: sticky flags, masks, summary and fault pin
// ==========================================================
// What this block does
// - UART mode: unlock ignores writes, reads zero
// - SPI: code A then start runs diagnostic
// - Reads keep unlock code, any write but an SPI unlock write clears
// - Chain mask blocks chain comm faults
// - Host mask blocks host port comm faults
// - Detect, tone, heartbeat masks block comm summary
// - Reg, sys, power masks block summary and pin
// - System clear wipes flags and summary, self-clears
// - System summary is any flag and unmasked
// - Power summary is any flag and unmasked
// - Register flags: bitflip, load, CRC
// - System flags: validate, digital reset, oscillator
// - Long timeout sets its flag
// - Short timeout only sets its flag
// - Power flags: five supply faults
// - Comm clear flag on its event, or on a ping in UART mode only
// - Second comm register: SPI and chain faults
// - Lower port bit error adds byte error
// - Enabled pin pulls low on unmasked fault
`timescale 1ns/10ps
`include "fa_map.svh"
module fa_top
  import fa_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        spi_mode_pin,
  input  wire logic [2:0]  reg_evt,
  input  wire logic [7:0]  sys_evt,
  input  wire logic [4:0]  pwr_evt,
  input  wire logic [6:0]  comm1_evt,
  input  wire logic        commclr_ping,
  input  wire logic [5:0]  comm2_evt,
  input  wire logic        lower_byte_evt,
  input  wire logic        wake_ping,
  input  wire logic        soft_reset,
  output logic             fault_out_n_o,
  output logic             fault_out_n_oe,
  output logic             fifo_diag_start,
  output logic             chain_rx_off,
  output fa_byte_t         summary
);

  // ========================================================
  // Local decode
  function automatic logic hit(input logic [15:0] a,
                               input fa_idx_t idx);
    hit = (a[15:2] == idx);
  endfunction

  fa_bus_t  bus_st;
  logic     spi_meta;
  logic     spi_mode;
  logic     rst_seen;
  logic     acc;
  logic     wr_acc;
  logic     rd_acc;
  logic     lane0;
  fa_byte_t wbyte;
  fa_byte_t clr;
  fa_byte_t mask;
  fa_byte_t ctrl;
  logic [3:0] unlock_code;
  logic [2:0] reg_q;
  fa_byte_t sys_q;
  logic [4:0] pwr_q;
  logic [6:0] comm1_q;
  logic [5:0] comm2_q;
  logic [1:0] ldbg_q;
  logic       reg_sum;
  fa_byte_t sys_set;
  logic [6:0] comm1_set;
  fa_byte_t sys_clr;
  logic [6:0] comm1_clr;
  logic [5:0] comm2_clr;
  logic       chain_f;
  logic       host_f;
  logic       sum_comm;
  fa_byte_t next_summary;
  fa_byte_t next_rbyte;
  logic       next_known;

  // ========================================================
  // Mode pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi_meta <= 1'b0;
      spi_mode <= 1'b0;
    end else if (ce) begin
      spi_meta <= spi_mode_pin;
      spi_mode <= spi_meta;
    end
  end

  // ========================================================
  // APB slave: no wait states, answer prepared in setup
  assign acc    = ce & psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign lane0  = pstrb[0];
  assign wbyte  = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_st <= FA_BUS_IDLE;
      pready <= 1'b0;
    end else if (ce) begin
      case (bus_st)
        FA_BUS_IDLE: begin
          if (psel && !penable) begin
            bus_st <= FA_BUS_ACC;
            pready <= 1'b1;
          end
        end
        FA_BUS_ACC: begin
          bus_st <= FA_BUS_IDLE;
          pready <= 1'b0;
        end
        default: begin
          bus_st <= FA_BUS_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    next_rbyte = `FA_RST_BYTE;
    next_known = 1'b1;
    if (hit(paddr, `FA_IDX_UNLOCK)) begin
      next_rbyte = spi_mode ? {4'h0, unlock_code} : `FA_RST_BYTE;
    end else if (hit(paddr, `FA_IDX_MASK)) begin
      next_rbyte = mask;
    end else if (hit(paddr, `FA_IDX_CLEAR)) begin
      next_rbyte = `FA_RST_BYTE;
    end else if (hit(paddr, `FA_IDX_CTRL)) begin
      next_rbyte = ctrl;
    end else if (hit(paddr, `FA_IDX_SUMMARY)) begin
      next_rbyte = next_summary;
    end else if (hit(paddr, `FA_IDX_REGF)) begin
      next_rbyte = {5'h00, reg_q};
    end else if (hit(paddr, `FA_IDX_SYSF)) begin
      next_rbyte = sys_q;
    end else if (hit(paddr, `FA_IDX_PWRF)) begin
      next_rbyte = {3'h0, pwr_q};
    end else if (hit(paddr, `FA_IDX_COMM1)) begin
      next_rbyte = {1'b0, comm1_q};
    end else if (hit(paddr, `FA_IDX_COMM2)) begin
      next_rbyte = {2'h0, comm2_q};
    end else if (hit(paddr, `FA_IDX_LDBG)) begin
      next_rbyte = {6'h00, ldbg_q};
    end else begin
      next_known = 1'b0;
    end
  end

  // Data is sampled in setup so it stands still over the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata  <= {24'h00_0000, next_rbyte};
      pslverr <= ~next_known;
    end
  end

  // ========================================================
  // Mask and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= `FA_RST_BYTE;
    end else if (wr_acc && lane0 && hit(paddr, `FA_IDX_MASK)) begin
      mask <= wbyte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `FA_RST_CTRL;
    end else if (wr_acc && lane0 && hit(paddr, `FA_IDX_CTRL)) begin
      ctrl <= {7'h00, wbyte[`FA_C_OUT_EN]};
    end
  end

  // ========================================================
  // Diagnostic unlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_code <= 4'h0;
    end else if (wr_acc) begin
      // any write clears, only an unlock write reloads
      if (hit(paddr, `FA_IDX_UNLOCK) && lane0 && spi_mode) begin
        unlock_code <= wbyte[3:0];
      end else begin
        unlock_code <= 4'h0;
      end
    end
  end

  // start honoured only while code A stands in SPI mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_diag_start <= 1'b0;
    end else if (ce) begin
      fifo_diag_start <= wr_acc && lane0 && spi_mode
                         && hit(paddr, `FA_IDX_CTRL)
                         && wbyte[`FA_C_DIAG_GO]
                         && unlock_code == `FA_UNLOCK_CODE;
    end
  end

  // ========================================================
  // Clear pulses: nothing is stored, so the bits read zero
  // writing 0 leaves flags alone
  assign clr = (wr_acc && lane0 && hit(paddr, `FA_IDX_CLEAR))
               ? wbyte : `FA_RST_BYTE;

  assign sys_clr   = {8{clr[`FA_B_SYS]}};
  assign comm1_clr = {clr[`FA_B_FCOMM], clr[`FA_B_TONE],
                      {2{clr[`FA_B_HB]}}, {3{clr[`FA_B_HOST]}}};
  assign comm2_clr = {{2{clr[`FA_B_HOST]}}, {4{clr[`FA_B_CHAIN]}}};

  // ========================================================
  // Flag sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen <= 1'b0;
    end else if (ce) begin
      rst_seen <= 1'b1;
    end
  end

  // digital reset flag raised once after release
  // timeouts just set their own flags
  always_comb begin
    sys_set = sys_evt;
    sys_set[`FA_SYS_DIGRST] = sys_evt[`FA_SYS_DIGRST] | ~rst_seen;
  end

  // ping-caused comm clear only counts in UART mode
  always_comb begin
    comm1_set = comm1_evt;
    comm1_set[`FA_C1_COMMCLR] = comm1_evt[`FA_C1_COMMCLR]
                                | (commclr_ping & ~spi_mode);
  end

  fa_sticky #(.W(3)) u_regf (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt (reg_evt),
    .clr     (3'h0),
    .q       (reg_q)
  );

  // system flags wiped as a whole
  fa_sticky #(.W(8)) u_sysf (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt (sys_set),
    .clr     (sys_clr),
    .q       (sys_q)
  );

  fa_sticky #(.W(5)) u_pwrf (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt (pwr_evt),
    .clr     ({5{clr[`FA_B_PWR]}}),
    .q       (pwr_q)
  );

  fa_sticky #(.W(7)) u_comm1 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt (comm1_set),
    .clr     (comm1_clr),
    .q       (comm1_q)
  );

  fa_sticky #(.W(6)) u_comm2 (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt (comm2_evt),
    .clr     (comm2_clr),
    .q       (comm2_q)
  );

  // a lower port bit error implies a byte error
  fa_sticky #(.W(2)) u_ldbg (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .set_evt ({comm2_evt[`FA_C2_LPHY],
               comm2_evt[`FA_C2_LPHY] | lower_byte_evt}),
    .clr     ({2{clr[`FA_B_CHAIN]}}),
    .q       (ldbg_q)
  );

  // register summary is its own sticky bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_sum <= 1'b0;
    end else if (ce) begin
      reg_sum <= (reg_sum & ~clr[`FA_B_REG])
                 | (|reg_evt & ~mask[`FA_B_REG]);
    end
  end

  // receivers stay off until a wake ping or soft reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_rx_off <= 1'b0;
    end else if (ce) begin
      if (sys_evt[`FA_SYS_SHDREC]) begin
        chain_rx_off <= 1'b1;
      end else if (wake_ping || soft_reset) begin
        chain_rx_off <= 1'b0;
      end
    end
  end

  // ========================================================
  // Masking and summary
  assign chain_f = |comm2_q[3:0];
  assign host_f  = |comm1_q[2:0] | |comm2_q[5:4];

  // each comm group has its own gate
  assign sum_comm = (chain_f & ~mask[`FA_B_CHAIN])
                  | (host_f & ~mask[`FA_B_HOST])
                  | (comm1_q[6] & ~mask[`FA_B_FCOMM])
                  | (comm1_q[5] & ~mask[`FA_B_TONE])
                  | (|comm1_q[4:3] & ~mask[`FA_B_HB]);

  // masks gate summary only, flags keep updating
  always_comb begin
    next_summary = `FA_RST_BYTE;
    next_summary[`FA_S_COMM] = sum_comm;
    next_summary[`FA_S_REG]  = reg_sum;
    next_summary[`FA_S_SYS]  = |sys_q & ~mask[`FA_B_SYS];
    next_summary[`FA_S_PWR]  = |pwr_q & ~mask[`FA_B_PWR];
  end

  // ========================================================
  // Fault pin, open drain: only ever drives low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary        <= `FA_RST_BYTE;
      fault_out_n_o  <= 1'b0;
      fault_out_n_oe <= 1'b0;
    end else if (ce) begin
      summary        <= next_summary;
      fault_out_n_o  <= 1'b0;
      // driver disabled when the enable is 0
      fault_out_n_oe <= ctrl[`FA_C_OUT_EN] & |next_summary;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_uart_unlock_zero: assert property (
    rd_acc && hit(paddr, `FA_IDX_UNLOCK) && !spi_mode
    |-> prdata == 32'h0000_0000)
    else $error("unlock reads nonzero in UART mode");

  a_write_clears_code: assert property (
    wr_acc && !hit(paddr, `FA_IDX_UNLOCK)
    |=> unlock_code == 4'h0)
    else $error("unlock code kept after a write");

  a_diag_needs_code: assert property (
    fifo_diag_start |-> $past(unlock_code) == `FA_UNLOCK_CODE
    && $past(spi_mode))
    else $error("diagnostic started without unlock");

  a_chain_masked: assert property (
    ce && mask[`FA_B_CHAIN] && !host_f && comm1_q[6:3] == 4'h0
    && !(|comm2_evt[5:4]) && comm1_evt == 7'h00 && !commclr_ping
    |=> !summary[`FA_S_COMM])
    else $error("chain fault passed its mask");

  a_host_unmasked: assert property (
    ce && !mask[`FA_B_HOST] && host_f
    |=> summary[`FA_S_COMM] ##1 summary[`FA_S_COMM] || !$past(ce)
    || $past(mask[`FA_B_HOST]) || !$past(host_f))
    else $error("host fault missing from summary");

  a_sys_clear: assert property (
    ce && clr[`FA_B_SYS] && sys_evt == 8'h00 && rst_seen
    |=> sys_q == 8'h00 ##1 !summary[`FA_S_SYS] || !$past(ce))
    else $error("system clear left flags set");

  a_pwr_summary: assert property (
    ce && |pwr_q && !mask[`FA_B_PWR] && !clr[`FA_B_PWR]
    |=> summary[`FA_S_PWR])
    else $error("power summary not raised");

  a_commclr_spi: assert property (
    ce && spi_mode && commclr_ping && !comm1_evt[`FA_C1_COMMCLR]
    && !comm1_q[`FA_C1_COMMCLR]
    |=> !comm1_q[`FA_C1_COMMCLR])
    else $error("comm clear set by ping in SPI mode");

  a_lower_byte: assert property (
    ce && comm2_evt[`FA_C2_LPHY] |=> ldbg_q == 2'b11)
    else $error("bit error without byte error");

  a_pin_low: assert property (
    ce && ctrl[`FA_C_OUT_EN] && |next_summary
    |=> fault_out_n_oe && !fault_out_n_o)
    else $error("fault pin not driven low");

  a_rx_off_hold: assert property (
    ce && sys_evt[`FA_SYS_SHDREC] |=> chain_rx_off)
    else $error("receivers not held off");
endmodule

// ===== fa_map.svh
// Register indexes, field positions and reset values of the fault block
`ifndef FA_MAP_SVH
`define FA_MAP_SVH

// ==========================================================
// Register indexes (byte address = index * 4)
`define FA_IDX_UNLOCK  14'h2010
`define FA_IDX_MASK    14'h2020
`define FA_IDX_CLEAR   14'h2030
`define FA_IDX_CTRL    14'h2040
`define FA_IDX_SUMMARY 14'h2100
`define FA_IDX_REGF    14'h2101
`define FA_IDX_SYSF    14'h2102
`define FA_IDX_PWRF    14'h2103
`define FA_IDX_COMM1   14'h2104
`define FA_IDX_COMM2   14'h2105
`define FA_IDX_LDBG    14'h2306

// ==========================================================
// Reset values
`define FA_RST_BYTE    8'h00
`define FA_RST_CTRL    8'h01

// ==========================================================
// Unlock code
`define FA_UNLOCK_CODE 4'hA

// ==========================================================
// Mask and clear bit positions (same layout in both)
`define FA_B_CHAIN     7
`define FA_B_HOST      6
`define FA_B_FCOMM     5
`define FA_B_TONE      4
`define FA_B_HB        3
`define FA_B_REG       2
`define FA_B_SYS       1
`define FA_B_PWR       0

// ==========================================================
// Summary, control and flag bit positions
`define FA_S_COMM      3
`define FA_S_REG       2
`define FA_S_SYS       1
`define FA_S_PWR       0
`define FA_C_OUT_EN    0
`define FA_C_DIAG_GO   1
`define FA_SYS_SHDREC  5
`define FA_SYS_DIGRST  4
`define FA_C1_COMMCLR  1
`define FA_C2_LPHY     2
`endif

// ===== fa_pkg.sv
// Types shared by the fault aggregation block
package fa_pkg;
  typedef logic [7:0]  fa_byte_t;
  typedef logic [13:0] fa_idx_t;
  typedef enum logic [1:0] {
    FA_BUS_IDLE = 2'b01,
    FA_BUS_ACC  = 2'b10
  } fa_bus_t;
endpackage

// ===== fa_sticky.sv
// Bank of sticky fault flags where a set beats a clear
`timescale 1ns/10ps
module fa_sticky
  import fa_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set_evt,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] q
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= (q & ~clr) | set_evt;
    end
  end
endmodule

// ===== fa_host_model.sv
// Host-side view of the open-drain fault pin with its pull-up
`timescale 1ns/10ps
module fa_host_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_lvl
);
  // ========================================================
  // Pin level
  // Pulled high unless driven
  // The pull-up is what the host sees, never a held value
  assign pin_lvl = pin_oe ? pin_o : 1'b1;
endmodule

// ===== tb_fault_aggregation_reporting.sv
// Self-checking bench for the fault aggregation block
`timescale 1ns/10ps
`include "fa_map.svh"
module tb_fault_aggregation_reporting
  import fa_pkg::*;
;
  logic        pclk, presetn, ce, psel, penable, pwrite, spi_mode_pin;
  logic        commclr_ping, lower_byte_evt, wake_ping, soft_reset;
  logic        pready, pslverr, pin_o, pin_oe, diag_go, rx_off, pin_lvl;
  logic        rd_err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [2:0]  reg_evt;
  logic [7:0]  sys_evt;
  logic [4:0]  pwr_evt;
  logic [6:0]  comm1_evt;
  logic [5:0]  comm2_evt;
  fa_byte_t    summary, rd_val;
  int          n_fail, n_tests, cyc, n_go;

  fa_top fa_top_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_mode_pin(spi_mode_pin), .reg_evt(reg_evt),
    .sys_evt(sys_evt), .pwr_evt(pwr_evt), .comm1_evt(comm1_evt),
    .commclr_ping(commclr_ping), .comm2_evt(comm2_evt),
    .lower_byte_evt(lower_byte_evt), .wake_ping(wake_ping),
    .soft_reset(soft_reset), .fault_out_n_o(pin_o),
    .fault_out_n_oe(pin_oe), .fifo_diag_start(diag_go),
    .chain_rx_off(rx_off), .summary(summary)
  );
  fa_host_model fa_host_model_inst (
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl)
  );

  // ========================================================
  // Clock, timeout and pulse count
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (diag_go === 1'b1) n_go++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ========================================================
  // Shared tasks
  task automatic chk(input string nm, input fa_byte_t e, input fa_byte_t g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input fa_idx_t i, input fa_byte_t d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    // Slave answers in the first access cycle
    chk("pready wait", 8'h01, 8'(k));
    rd_val = prdata[7:0];
    rd_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input fa_idx_t i, input fa_byte_t d);
    apb(1'b1, i, d);
  endtask
  task automatic rdc(input string nm, input fa_idx_t i, input fa_byte_t e);
    apb(1'b0, i, 8'h00);
    chk(nm, e, rd_val);
  endtask
  task automatic pin(input logic e);
    // Pin enable is registered alongside the summary, one register stage
    repeat (3) @(posedge pclk);
    chk("fault pin", {7'h00, e}, {7'h00, pin_lvl});
  endtask
  task automatic ev(input int g, input int b);
    @(posedge pclk);
    case (g)
      0: reg_evt <= 3'(1 << b);
      1: sys_evt <= 8'(1 << b);
      2: pwr_evt <= 5'(1 << b);
      3: comm1_evt <= 7'(1 << b);
      4: comm2_evt <= 6'(1 << b);
      5: commclr_ping <= 1'b1;
      6: wake_ping <= 1'b1;
      7: soft_reset <= 1'b1;
      default: lower_byte_evt <= 1'b1;
    endcase
    @(posedge pclk);
    {reg_evt, sys_evt, pwr_evt, comm1_evt, comm2_evt} <= '0;
    {commclr_ping, wake_ping, soft_reset, lower_byte_evt} <= '0;
  endtask

  // ========================================================
  // Scenarios
  task automatic t_reset;
    rdc("sys flags", `FA_IDX_SYSF, 8'h10);
    rdc("summary", `FA_IDX_SUMMARY, 8'h02);
    chk("summary port", 8'h02, summary);
    pin(1'b0);
    rdc("mask", `FA_IDX_MASK, 8'h00);
    rdc("unlock", `FA_IDX_UNLOCK, 8'h00);
    rdc("pwr flags", `FA_IDX_PWRF, 8'h00);
    rdc("comm1", `FA_IDX_COMM1, 8'h00);
    rdc("comm2", `FA_IDX_COMM2, 8'h00);
    rdc("control", `FA_IDX_CTRL, 8'h01);
    apb(1'b0, 14'h0100, 8'h00);
    chk("slave error", 8'h01, {7'h00, rd_err});
  endtask
  task automatic t_sys;
    for (int b = 0; b < 8; b++) begin
      wr(`FA_IDX_CLEAR, 8'h02);
      rdc("sys flags", `FA_IDX_SYSF, 8'h00);
      rdc("summary", `FA_IDX_SUMMARY, 8'h00);
      rdc("clear", `FA_IDX_CLEAR, 8'h00);
      ev(1, b);
      rdc("sys flags", `FA_IDX_SYSF, 8'(1 << b));
      rdc("summary", `FA_IDX_SUMMARY, 8'h02);
    end
    wr(`FA_IDX_MASK, 8'h02);
    rdc("summary", `FA_IDX_SUMMARY, 8'h00);
    rdc("sys flags", `FA_IDX_SYSF, 8'h80);
    pin(1'b1);
    wr(`FA_IDX_MASK, 8'h00);
    wr(`FA_IDX_CLEAR, 8'h02);
    pin(1'b1);
    ev(1, 5);
    @(posedge pclk);
    chk("rx off", 8'h01, {7'h00, rx_off});
    ev(6, 0);
    repeat (2) @(posedge pclk);
    chk("rx off", 8'h00, {7'h00, rx_off});
    ev(1, 5);
    ev(7, 0);
    repeat (2) @(posedge pclk);
    chk("rx off", 8'h00, {7'h00, rx_off});
    wr(`FA_IDX_CLEAR, 8'h02);
  endtask
  task automatic t_pwr_reg;
    for (int b = 0; b < 5; b++) begin
      ev(2, b);
      rdc("pwr flags", `FA_IDX_PWRF, 8'(1 << b));
      rdc("summary", `FA_IDX_SUMMARY, 8'h01);
      wr(`FA_IDX_MASK, 8'h01);
      rdc("summary", `FA_IDX_SUMMARY, 8'h00);
      wr(`FA_IDX_MASK, 8'h00);
      wr(`FA_IDX_CLEAR, 8'h01);
      rdc("pwr flags", `FA_IDX_PWRF, 8'h00);
    end
    for (int b = 0; b < 3; b++) begin
      ev(0, b);
      rdc("reg flags", `FA_IDX_REGF, 8'((2 << b) - 1));
    end
    rdc("summary", `FA_IDX_SUMMARY, 8'h04);
    wr(`FA_IDX_CLEAR, 8'h04);
    rdc("summary", `FA_IDX_SUMMARY, 8'h00);
    wr(`FA_IDX_MASK, 8'h04);
    ev(0, 1);
    rdc("summary", `FA_IDX_SUMMARY, 8'h00);
    rdc("reg flags", `FA_IDX_REGF, 8'h07);
    wr(`FA_IDX_MASK, 8'h00);
  endtask
  task automatic t_comm;
    int      mb [13];
    int      g;
    int      b;
    fa_idx_t ix;
    mb = '{6, 6, 6, 3, 3, 4, 5, 7, 7, 7, 7, 6, 6};
    for (int i = 0; i < 13; i++) begin
      g  = (i < 7) ? 3 : 4;
      b  = (i < 7) ? i : i - 7;
      ix = (i < 7) ? `FA_IDX_COMM1 : `FA_IDX_COMM2;
      wr(`FA_IDX_MASK, 8'(1 << mb[i]));
      ev(g, b);
      rdc("comm flags", ix, 8'(1 << b));
      rdc("summary", `FA_IDX_SUMMARY, 8'h00);
      pin(1'b1);
      wr(`FA_IDX_MASK, 8'h00);
      rdc("summary", `FA_IDX_SUMMARY, 8'h08);
      pin(1'b0);
      wr(`FA_IDX_CLEAR, 8'(1 << mb[i]));
      rdc("comm flags", ix, 8'h00);
    end
    ev(4, 2);
    rdc("lower debug", `FA_IDX_LDBG, 8'h03);
    wr(`FA_IDX_CLEAR, 8'h80);
    rdc("lower debug", `FA_IDX_LDBG, 8'h00);
    ev(8, 0);
    rdc("lower debug", `FA_IDX_LDBG, 8'h01);
    wr(`FA_IDX_CLEAR, 8'h80);
  endtask
  task automatic t_hold;
    // A low clock enable must swallow an event pulse
    @(posedge pclk);
    ce <= 1'b0;
    ev(2, 0);
    @(posedge pclk);
    ce <= 1'b1;
    rdc("pwr flags", `FA_IDX_PWRF, 8'h00);
    // Byte lane 0 disabled: the write must not land
    pstrb <= 4'hE;
    wr(`FA_IDX_MASK, 8'hFF);
    pstrb <= 4'hF;
    rdc("mask", `FA_IDX_MASK, 8'h00);
  endtask
  task automatic t_mode;
    ev(5, 0);
    rdc("comm1", `FA_IDX_COMM1, 8'h02);
    wr(`FA_IDX_CLEAR, 8'h40);
    spi_mode_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    ev(5, 0);
    rdc("comm1", `FA_IDX_COMM1, 8'h00);
    wr(`FA_IDX_UNLOCK, 8'h2A);
    rdc("unlock", `FA_IDX_UNLOCK, 8'h0A);
    rdc("unlock", `FA_IDX_UNLOCK, 8'h0A);
    wr(`FA_IDX_CTRL, 8'h03);
    repeat (2) @(posedge pclk);
    chk("diag pulses", 8'h01, 8'(n_go));
    rdc("unlock", `FA_IDX_UNLOCK, 8'h00);
    wr(`FA_IDX_CTRL, 8'h03);
    wr(`FA_IDX_UNLOCK, 8'h25);
    wr(`FA_IDX_CTRL, 8'h03);
    wr(`FA_IDX_UNLOCK, 8'h0A);
    wr(`FA_IDX_MASK, 8'h00);
    rdc("unlock", `FA_IDX_UNLOCK, 8'h00);
    spi_mode_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    wr(`FA_IDX_UNLOCK, 8'h0A);
    rdc("unlock", `FA_IDX_UNLOCK, 8'h00);
    wr(`FA_IDX_CTRL, 8'h03);
    repeat (2) @(posedge pclk);
    chk("diag pulses", 8'h01, 8'(n_go));
    ev(1, 0);
    wr(`FA_IDX_CTRL, 8'h00);
    pin(1'b1);
    wr(`FA_IDX_CTRL, 8'h01);
    pin(1'b0);
  endtask

  // ========================================================
  // Verdict
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, spi_mode_pin} = '0;
    {reg_evt, sys_evt, pwr_evt, comm1_evt, comm2_evt} = '0;
    {commclr_ping, wake_ping, soft_reset, lower_byte_evt} = '0;
    ce     = 1'b1;
    pstrb  = 4'hF;
    paddr  = 16'h0000;
    pwdata = 32'h00000000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sys();
    t_pwr_reg();
    t_hold();
    t_comm();
    t_mode();
    finish_test();
  end
endmodule
